// *** shared/cap8_regs.vh ***
// Register map and field layout of the three-channel 8-bit modulator block
// Included by every design file; definitions only
`ifndef CAP8_REGS_VH
`define CAP8_REGS_VH

`define CAP8_ADDR_W 8
`define CAP8_A_CPL1 8'he9
`define CAP8_A_CPH1 8'hea
`define CAP8_A_CPL2 8'heb
`define CAP8_A_CPH2 8'hec
`define CAP8_A_CPL0 8'hfb
`define CAP8_A_CPH0 8'hfc
`define CAP8_A_MODE0 8'hd0
`define CAP8_A_MODE1 8'hd1
`define CAP8_A_MODE2 8'hd2
`define CAP8_A_CFG 8'hd3
`define CAP8_A_CNT 8'hd4
`define CAP8_A_FLAGS 8'hd5
`define CAP8_A_CTRL 8'hd6

// Channel mode register fields
`define CAP8_M_MAT 0
`define CAP8_M_PWM 1
`define CAP8_M_ECOM 2

// Modulator configuration register fields
`define CAP8_C_CYCLE_LENGTH_SELECT_LO 0
`define CAP8_C_CYCLE_LENGTH_SELECT_HI 1
`define CAP8_C_CYCLE_OVERFLOW_FLAG 5
`define CAP8_C_RELOAD_ACCESS_SELECT 7
`define CAP8_CYCLE_LENGTH_SELECT_8BIT 2'h0

// Counter control register fields
`define CAP8_K_RUN 0

`define CAP8_RST_BYTE 8'h00
`define CAP8_CNT_MAX 8'hff
`define CAP8_CNT_ZERO 8'h00

`endif

// *** sim/cap8_load.sv ***
// External load on one modulated output pin: measures high time and period
// Assumes the pin is a registered level in the clk domain
`timescale 1ns/10ps
`default_nettype none
module cap8_load (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic [8:0] hi_len,
    output logic [8:0] per_len,
    output logic [7:0] falls
);
    logic [8:0] hi_q;
    logic [8:0] per_q;
    logic pin_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {hi_q, per_q, pin_q, hi_len, per_len, falls} <= '0;
        end else begin
            pin_q <= pin;
            hi_q <= pin ? hi_q + 9'h1 : 9'h0;
            per_q <= per_q + 9'h1;
            if (pin_q && !pin) begin
                hi_len <= hi_q;
                per_len <= per_q;
                per_q <= 9'h1;
                falls <= falls + 8'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/cap8_pwm_asserts.sv ***
// Port-level checker for the modulator block, attached by bind
// Assumes the register map of the design header and one clock domain
`timescale 1ns/10ps
`default_nettype none
module cap8_pwm_asserts #(
    parameter NCH = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata_q,
    input wire logic [NCH-1:0] modulated_output_pin_q
);
    logic [2:0] m0_q;
    logic [1:0] cl_q;
    logic ar_q;
    logic run_q;
    wire act0 = m0_q[2] & m0_q[1] & (cl_q == 2'h0);
    // Mirror of channel 0 mode, length, reload select and run
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {m0_q, cl_q, ar_q, run_q} <= '0;
        end else if (wr) begin
            if (addr == 8'hd0) m0_q <= wdata[2:0];
            if (addr == 8'hfb && !ar_q) m0_q[2] <= 1'b0;
            if (addr == 8'hfc && !ar_q) m0_q[2] <= 1'b1;
            if (addr == 8'hd3) {ar_q, cl_q} <= {wdata[7], wdata[1:0]};
            if (addr == 8'hd6) run_q <= wdata[0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr_rd(logic [7:0] w, logic [7:0] r);
        wr && addr == w ##1 !wr ##1 rd && addr == r;
    endsequence
    sequence s_cnt2(logic t);
        rd && addr == 8'hd4 && tick == t ##1 rd && addr == 8'hd4;
    endsequence
    property p_rd_idle;
        !$past(rd) |-> rdata_q == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_readback;
        !tick [*2] ##1 (s_wr_rd(8'hfb, 8'hfb) and !tick [*3]) |=> rdata_q == $past(wdata, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("compare low readback");
    property p_low_clears;
        !ar_q ##0 s_wr_rd(8'hfb, 8'hd0) |=> !rdata_q[2];
    endproperty
    a_low_clears: assert property (p_low_clears) else $error("enable not cleared");
    property p_high_sets;
        !ar_q ##0 s_wr_rd(8'hfc, 8'hd0) |=> rdata_q[2];
    endproperty
    a_high_sets: assert property (p_high_sets) else $error("enable not set");
    property p_reload_access_select_keeps;
        ar_q ##0 s_wr_rd(8'hfc, 8'hd0) |=> rdata_q[2] == m0_q[2];
    endproperty
    a_reload_access_select_keeps: assert property (p_reload_access_select_keeps) else $error("reload write moved enable");
    property p_cnt_hold;
        s_cnt2(1'b0) |=> rdata_q == $past(rdata_q);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved without tick");
    property p_cnt_step;
        s_cnt2(1'b1) |=> rdata_q == $past(rdata_q) + {7'h0, run_q};
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count step per tick");
    property p_rise_active;
        $rose(modulated_output_pin_q[0]) |-> $past(act0) || $past(act0, 2) || $past(act0, 3);
    endproperty
    a_rise_active: assert property (p_rise_active) else $error("pin set while idle");
endmodule
bind cap8_pwm cap8_pwm_asserts #(.NCH(NCH)) i_chk (
    .clk(clk), .rst(rst), .tick(tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .modulated_output_pin_q(modulated_output_pin_q)
);
`default_nettype wire

// *** sim/test_cap8_pwm.sv ***
// Self-checking bench for the three-channel modulator block
// Assumes the load model and checker files are compiled before it
`timescale 1ns/10ps
`default_nettype none
module test_cap8_pwm;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [7:0] v;
    logic [7:0] v2;
    logic [7:0] n0;
    wire [7:0] rdata_q;
    wire [2:0] pin;
    wire [8:0] hi_len;
    wire [8:0] per_len;
    wire [7:0] falls;
    int fail_count = 0;
    int checks_done = 0;
    logic [7:0] lo_a [3] = '{8'hfb, 8'he9, 8'heb};
    logic [7:0] hi_a [3] = '{8'hfc, 8'hea, 8'hec};
    logic [7:0] rh [6] = '{8'h01, 8'h80, 8'hff, 8'h40, 8'hfe, 8'hc0};
    always #4 clk = ~clk;
    cap8_pwm #(.NCH(3)) i_dut (.clk(clk), .rst(rst), .tick(tick), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata_q(rdata_q), .modulated_output_pin_q(pin));
    cap8_load i_load (.clk(clk), .rst(rst), .pin(pin[sel]), .hi_len(hi_len),
        .per_len(per_len), .falls(falls));
    task automatic test_done;
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata_q;
    endtask
    task automatic cnt2(input logic t);
        @(posedge clk);
        rd <= 1'b1;
        addr <= 8'hd4;
        tick <= t;
        @(posedge clk);
        tick <= 1'b0;
        #1 v = rdata_q;
        @(posedge clk);
        rd <= 1'b0;
        #1 v2 = rdata_q;
        check(v2 === v + {7'h0, t}, "count step");
    endtask
    // Settle for 300 cycles, then the selected pin must hold one level for 300 more
    task automatic hold(input logic val, input string msg);
        logic bad;
        bad = 1'b0;
        repeat (300) @(posedge clk);
        repeat (300) begin
            @(negedge clk);
            if (pin[sel] !== val) bad = 1'b1;
        end
        check(!bad, msg);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            rreg(lo_a[i], v);
            check(v === 8'h00, "low reset");
            rreg(hi_a[i], v);
            check(v === 8'h00, "high reset");
        end
        rreg(8'h00, v);
        check(v === 8'h00, "unmapped read");
        wreg(8'hd6, 8'h01);
        tick <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            sel = 2'(i % 3);
            wreg(8'hd0 + {6'h0, sel}, 8'h06);
            // Low byte differs from high byte, so only the reload gives the right high time
            wreg(lo_a[sel], ~rh[i]);
            wreg(hi_a[sel], rh[i]);
            n0 = falls;
            for (int k = 0; k < 1200 && falls < n0 + 8'h3; k++) @(posedge clk);
            check(hi_len === 9'h100 - {1'b0, rh[i]}, "high time");
            check(per_len === 9'h100, "period");
        end
        sel = 2'h0;
        wreg(8'hfb, 8'h00);
        wreg(8'hfc, 8'h00);
        hold(1'b1, "full duty");
        wreg(8'hfb, 8'h40);
        rreg(8'hd0, v);
        check(v[2] === 1'b0, "low write enable");
        hold(1'b0, "zero duty");
        wreg(8'hd5, 8'h00);
        wreg(8'hd3, 8'h00);
        repeat (300) @(posedge clk);
        rreg(8'hd5, v);
        check(v[2:0] === 3'h0, "no match flag");
        rreg(8'hd3, v);
        check(v[5] === 1'b1, "overflow flag");
        wreg(8'hd1, 8'h07);
        wreg(8'hd5, 8'h00);
        repeat (300) @(posedge clk);
        rreg(8'hd5, v);
        check(v[2:0] === 3'h2, "match flag");
        sel = 2'h1;
        wreg(8'hd3, 8'h01);
        hold(1'b0, "length not 8");
        wreg(8'hd3, 8'h00);
        wreg(8'hfc, 8'h40);
        rreg(8'hd0, v);
        check(v[2] === 1'b1, "high write enable");
        cnt2(1'b1);
        cnt2(1'b0);
        repeat (3) @(posedge clk);
        wreg(8'hfb, 8'h33);
        rreg(8'hfb, v);
        check(v === 8'h33, "low readback");
        wreg(8'hd3, 8'h80);
        wreg(8'hfc, 8'ha5);
        rreg(8'hd0, v);
        check(v[2] === 1'b0, "reload write enable");
        rreg(8'hfc, v);
        check(v === 8'ha5, "reload readback");
        wreg(8'hd3, 8'h00);
        rreg(8'hfc, v);
        check(v === 8'h40, "compare high kept");
        rreg(8'hd3, v);
        check(v === 8'h00, "overflow flag cleared");
        // Reset in mid-run must bring channel 0 compare high and mode, and every pin, back to zero
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rreg(8'hfc, v);
        check(v === 8'h00, "high after reset");
        rreg(8'hd0, v);
        check(v === 8'h00, "mode after reset");
        check(pin === 3'h0, "pin after reset");
        test_done;
    end
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        test_done;
    end
endmodule
`default_nettype wire

// *** verilog/cap8_channel.v ***
// One modulator channel: compare and output flip-flop
// Assumes step/wrap pulses from the timebase, registered on the same edge that moves the count
`timescale 1ns/10ps
`default_nettype none
`include "cap8_regs.vh"

module cap8_channel #(
    parameter W = 8
) (
    input wire clk,
    input wire rst,
    input wire active,
    input wire step,
    input wire wrap,
    input wire [W-1:0] count,
    input wire [W-1:0] cmp_lo,
    output wire match,
    output reg out_q
);

    // The count held after step is the new value; compare it once per tick
    assign match = active & step & (count == cmp_lo);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            out_q <= 1'b0;
        end else if (!active) begin
            out_q <= 1'b0;
        end else if (match) begin
            out_q <= 1'b1;
        end else if (wrap) begin
            out_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** verilog/cap8_pwm.v ***
// Three-channel 8-bit pulse width modulator of a counter array
// Assumes a plain register port and a timebase tick synchronous to clk
//
// Operation
// - All modulator channels share one cycle length
// - Other channels run independently of modulator channels
// - Output set when counter equals compare low
// - Output cleared on counter low overflow
// - Overflow reloads compare low from compare high
// - Mode needs enable, modulator bit, length 00
// - Match flag enable sets compare event flag
// - Overflow sets cycle overflow flag every 256
// - Writing compare low clears comparator enable
// - Writing compare high sets comparator enable
// - High time is 256 minus compare high
// - Disabled comparator gives zero percent duty
// - Reload select picks compare or auto-reload
// - Low register bits 7:0, high 15:8
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "cap8_regs.vh"

module cap8_pwm #(
    parameter NCH = 3
) (
    input wire clk,
    input wire rst,
    input wire tick,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata_q,
    output reg [NCH-1:0] modulated_output_pin_q
);

    reg [7:0] cmp_lo_q [0:NCH-1];
    reg [7:0] cmp_hi_q [0:NCH-1];
    reg [7:0] arl_lo_q [0:NCH-1];
    reg [7:0] arl_hi_q [0:NCH-1];
    reg [NCH-1:0] comparator_enable_q;
    reg [NCH-1:0] modulator_mode_bit_q;
    reg [NCH-1:0] match_flag_enable_q;
    reg [NCH-1:0] compare_event_flag_q;
    reg cycle_overflow_flag_q;
    reg reload_access_select_q;
    reg [1:0] cycle_length_select_q;
    reg run_q;

    wire [7:0] counter_low_byte;
    wire step;
    wire wrap;
    wire [NCH-1:0] match;
    wire [NCH-1:0] out_w;
    wire [NCH-1:0] active;

    // Map an address to a channel index of a low, high or mode byte, or 3 if none
    function [1:0] lo_ch;
        input [7:0] a;
        begin
            case (a)
                `CAP8_A_CPL0: lo_ch = 2'h0;
                `CAP8_A_CPL1: lo_ch = 2'h1;
                `CAP8_A_CPL2: lo_ch = 2'h2;
                default: lo_ch = 2'h3;
            endcase
        end
    endfunction

    function [1:0] hi_ch;
        input [7:0] a;
        begin
            case (a)
                `CAP8_A_CPH0: hi_ch = 2'h0;
                `CAP8_A_CPH1: hi_ch = 2'h1;
                `CAP8_A_CPH2: hi_ch = 2'h2;
                default: hi_ch = 2'h3;
            endcase
        end
    endfunction

    function [1:0] mode_ch;
        input [7:0] a;
        begin
            case (a)
                `CAP8_A_MODE0: mode_ch = 2'h0;
                `CAP8_A_MODE1: mode_ch = 2'h1;
                `CAP8_A_MODE2: mode_ch = 2'h2;
                default: mode_ch = 2'h3;
            endcase
        end
    endfunction

    wire [1:0] wl = lo_ch(addr);
    wire [1:0] wh = hi_ch(addr);
    wire [1:0] wm = mode_ch(addr);

    // One shared length field governs every modulator channel
    wire len8 = (cycle_length_select_q == `CAP8_CYCLE_LENGTH_SELECT_8BIT);

    cap8_timebase #(
        .W(8)
    ) u_tb (
        .clk(clk),
        .rst(rst),
        .run(run_q),
        .tick(tick),
        .count_q(counter_low_byte),
        .step_q(step),
        .wrap_q(wrap)
    );

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            // Channels outside this mode have their output flip-flop held at zero
            assign active[g] = comparator_enable_q[g] & modulator_mode_bit_q[g] & len8;
            cap8_channel #(
                .W(8)
            ) u_ch (
                .clk(clk),
                .rst(rst),
                .active(active[g]),
                .step(step),
                .wrap(wrap),
                .count(counter_low_byte),
                .cmp_lo(cmp_lo_q[g]),
                .match(match[g]),
                .out_q(out_w[g])
            );
        end
    endgenerate

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            modulated_output_pin_q <= {NCH{1'b0}};
        end else begin
            modulated_output_pin_q <= out_w;
        end
    end

    integer i;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < NCH; i = i + 1) begin
                cmp_lo_q[i] <= `CAP8_RST_BYTE;
                cmp_hi_q[i] <= `CAP8_RST_BYTE;
                arl_lo_q[i] <= `CAP8_RST_BYTE;
                arl_hi_q[i] <= `CAP8_RST_BYTE;
            end
            comparator_enable_q <= {NCH{1'b0}};
            modulator_mode_bit_q <= {NCH{1'b0}};
            match_flag_enable_q <= {NCH{1'b0}};
            compare_event_flag_q <= {NCH{1'b0}};
            cycle_overflow_flag_q <= 1'b0;
            reload_access_select_q <= 1'b0;
            cycle_length_select_q <= 2'h0;
            run_q <= 1'b0;
        end else begin
            for (i = 0; i < NCH; i = i + 1) begin
                // Hardware reload first; a software write in the same cycle wins
                if (wrap && active[i]) begin
                    cmp_lo_q[i] <= cmp_hi_q[i];
                end
                if (wr && wl == i) begin
                    if (reload_access_select_q) begin
                        arl_lo_q[i] <= wdata;
                    end else begin
                        cmp_lo_q[i] <= wdata;
                        comparator_enable_q[i] <= 1'b0;
                    end
                end
                if (wr && wh == i) begin
                    if (reload_access_select_q) begin
                        arl_hi_q[i] <= wdata;
                    end else begin
                        cmp_hi_q[i] <= wdata;
                        comparator_enable_q[i] <= 1'b1;
                    end
                end
                if (wr && wm == i) begin
                    match_flag_enable_q[i] <= wdata[`CAP8_M_MAT];
                    modulator_mode_bit_q[i] <= wdata[`CAP8_M_PWM];
                    comparator_enable_q[i] <= wdata[`CAP8_M_ECOM];
                end
            end
            // Write-zero clears a flag, but a same-cycle event keeps it set
            if (wr && addr == `CAP8_A_FLAGS) begin
                compare_event_flag_q <= (compare_event_flag_q & wdata[NCH-1:0])
                    | (match & match_flag_enable_q);
            end else begin
                compare_event_flag_q <= compare_event_flag_q | (match & match_flag_enable_q);
            end
            if (wr && addr == `CAP8_A_CFG) begin
                cycle_length_select_q <= wdata[`CAP8_C_CYCLE_LENGTH_SELECT_HI:`CAP8_C_CYCLE_LENGTH_SELECT_LO];
                reload_access_select_q <= wdata[`CAP8_C_RELOAD_ACCESS_SELECT];
                cycle_overflow_flag_q <= (cycle_overflow_flag_q & wdata[`CAP8_C_CYCLE_OVERFLOW_FLAG]) | wrap;
            end else if (wrap) begin
                cycle_overflow_flag_q <= 1'b1;
            end
            if (wr && addr == `CAP8_A_CTRL) begin
                run_q <= wdata[`CAP8_K_RUN];
            end
        end
    end

    reg [7:0] rd_d;
    always @* begin
        rd_d = 8'h00;
        if (wl != 2'h3) begin
            rd_d = reload_access_select_q ? arl_lo_q[wl] : cmp_lo_q[wl];
        end else if (wh != 2'h3) begin
            rd_d = reload_access_select_q ? arl_hi_q[wh] : cmp_hi_q[wh];
        end else if (wm != 2'h3) begin
            rd_d[`CAP8_M_MAT] = match_flag_enable_q[wm];
            rd_d[`CAP8_M_PWM] = modulator_mode_bit_q[wm];
            rd_d[`CAP8_M_ECOM] = comparator_enable_q[wm];
        end else begin
            case (addr)
                `CAP8_A_CFG: begin
                    rd_d[`CAP8_C_CYCLE_LENGTH_SELECT_HI:`CAP8_C_CYCLE_LENGTH_SELECT_LO] = cycle_length_select_q;
                    rd_d[`CAP8_C_CYCLE_OVERFLOW_FLAG] = cycle_overflow_flag_q;
                    rd_d[`CAP8_C_RELOAD_ACCESS_SELECT] = reload_access_select_q;
                end
                `CAP8_A_CNT: rd_d = counter_low_byte;
                `CAP8_A_FLAGS: rd_d[NCH-1:0] = compare_event_flag_q;
                `CAP8_A_CTRL: rd_d[`CAP8_K_RUN] = run_q;
                default: rd_d = 8'h00;
            endcase
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            rdata_q <= rd_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// *** verilog/cap8_timebase.v ***
// Counter-array timebase: low-byte counter advancing on each tick while run is set
// Assumes one clock domain; tick and run are synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "cap8_regs.vh"

module cap8_timebase #(
    parameter W = 8
) (
    input wire clk,
    input wire rst,
    input wire run,
    input wire tick,
    output reg [W-1:0] count_q,
    output reg step_q,
    output reg wrap_q
);

    wire adv = run & tick;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= {W{1'b0}};
            step_q <= 1'b0;
            wrap_q <= 1'b0;
        end else begin
            step_q <= adv;
            wrap_q <= adv & (&count_q);
            if (adv) begin
                count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule
`default_nettype wire
